// [tb/eight_bit_timer_counter_bench.sv]
// eight_bit_timer_counter_bench: self-checking bench for the tmr8 timer
// assumes tmr8_pkg offsets and divisors and a 20 mhz system clock
`timescale 1ns/1ps
module eight_bit_timer_counter_bench;
    import tmr8_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cyc_i = 1'h0, stb = 1'h0, we = 1'h0, stop = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack, ev, div_pin, pw_pin, irq;
    logic irq_q = 1'h0, div_q = 1'h1, pw_q = 1'h1; // last seen outputs
    int cyc = 0, num_errors = 0, compares = 0;
    int irq_t, div_t, pl_t, lw, w1, c, n;
    int tick[4] = '{int'(div_000), int'(div_001), int'(div_010), int'(div_011)};
    logic [31:0] exp_rd[$]; // notes: read data, irq and divider intervals
    int exp_irq[$], exp_div[$];
    // 50 ns clock
    always #25 clk = ~clk;
    tmr8 uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc_i), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .event_input_pin(ev), .stop_mode_req(stop), .divider_output_pin(div_pin),
        .pulse_width_output_pin(pw_pin), .irq_o(irq));
    tmr8_event_src src (.clk(clk), .event_input_pin(ev));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask : check
    // counts, verdict, end of run
    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc_i <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'h1) @(posedge clk);
        cyc_i <= 1'h0;
        stb <= 1'h0;
    endtask : wb
    // read with its expected data noted first
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        wb(a, 1'h0, 32'h0000_0000);
    endtask : rd
    // wait for irq to drop, then for its next rise
    task automatic wait_irq();
        n = 0;
        while (irq === 1'h1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        while (irq !== 1'h1 && n < 12000) begin
            @(posedge clk);
            n++;
        end
        check(irq, 1'h1);
    endtask : wait_irq
    // cycle count and hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 40000) begin
            num_errors++;
            test_done();
        end
    end
    // watcher: takes the oldest note whenever a result shows
    always @(negedge clk) begin
        if (ack && cyc_i && !we && exp_rd.size() > 0) begin
            check(dat_o, exp_rd.pop_front());
        end
        if (irq && !irq_q) begin
            if (exp_irq.size() > 0) check(cyc - irq_t, exp_irq.pop_front());
            irq_t = cyc;
        end
        if (div_pin !== div_q) begin
            if (exp_div.size() > 0) check(cyc - div_t, exp_div.pop_front());
            div_t = cyc;
        end
        // low phase width of the pulse output
        if (pw_pin && !pw_q) lw = cyc - pl_t;
        if (!pw_pin && pw_q) pl_t = cyc;
        irq_q = irq;
        div_q = div_pin;
        pw_q = pw_pin;
    end
    initial begin
        void'($urandom(32'h812e));
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        check({div_pin, pw_pin, irq}, 3'h6);
        rd(ctrl_off, {24'h00_0000, ctrl_rst});
        rd(cmp_off, {24'h00_0000, cmp_rst});
        rd(stat_off, 32'h0000_0000);
        rd(4'h2, 32'h0000_0000);
        wb(ctrl_off, 1'h1, 32'h0000_00c2);
        rd(ctrl_off, 32'h0000_0002);
        wb(mask_off, 1'h1, 32'h0000_0001);
        // compare set while stopped, mode unchanged
        for (int k = 0; k < 4; k++) begin
            c = (k == 0) ? 1 : 1 + $urandom % 8;
            wb(ctrl_off, 1'h1, k);
            wb(cmp_off, 1'h1, c);
            wb(ctrl_off, 1'h1, 32'h0000_0020 | k);
            wait_irq();
            repeat (2) begin
                exp_irq.push_back((c + 1) * tick[k]);
                wb(stat_off, 1'h1, 32'h0000_0001);
                wait_irq();
            end
            wb(ctrl_off, 1'h1, k);
            wb(stat_off, 1'h1, 32'h0000_0001);
        end
        c = 1 + $urandom % 4;
        wb(ctrl_off, 1'h1, 32'h0000_0012);
        wb(cmp_off, 1'h1, c);
        wb(ctrl_off, 1'h1, 32'h0000_0032);
        n = 0;
        while (div_pin !== 1'h0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        exp_div.push_back((c + 1) * tick[2]);
        exp_div.push_back((c + 1) * tick[2]);
        while (exp_div.size() > 0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        check(div_pin, 1'h0);
        wb(ctrl_off, 1'h1, 32'h0000_0012);
        repeat (2) @(posedge clk);
        check(div_pin, 1'h1);
        wb(stat_off, 1'h1, 32'h0000_0001);
        // pulse on code 100, compare rewritten after irq
        wb(ctrl_off, 1'h1, 32'h0000_001c);
        wb(cmp_off, 1'h1, 32'h0000_0040);
        wb(ctrl_off, 1'h1, 32'h0000_003c);
        wait_irq();
        w1 = lw;
        wb(cmp_off, 1'h1, 32'h0000_0080);
        exp_irq.push_back(256 * int'(div_100));
        wb(stat_off, 1'h1, 32'h0000_0001);
        wait_irq();
        check(lw, w1);
        exp_irq.push_back(256 * int'(div_100));
        wb(stat_off, 1'h1, 32'h0000_0001);
        wait_irq();
        check(lw, w1 - 32'h0000_0040 * int'(div_100));
        check(pw_pin, 1'h1);
        wb(ctrl_off, 1'h1, 32'h0000_001c);
        wb(stat_off, 1'h1, 32'h0000_0001);
        // event mode on code 111, no internal tick
        c = 2 + $urandom % 3;
        wb(ctrl_off, 1'h1, 32'h0000_000f);
        wb(cmp_off, 1'h1, c);
        wb(ctrl_off, 1'h1, 32'h0000_002f);
        repeat (2) begin
            repeat (c - 1) src.pulse();
            src.drive(1'h1);
            rd(stat_off, 32'h0000_0000);
            src.drive(1'h0);
            rd(stat_off, 32'h0000_0001);
            wb(stat_off, 1'h1, 32'h0000_0001);
        end
        wb(ctrl_off, 1'h1, 32'h0000_000f);
        // stop entry while running, codes 101 and 110 never used
        wb(ctrl_off, 1'h1, 32'h0000_0003);
        wb(cmp_off, 1'h1, 32'h0000_00ff);
        wb(ctrl_off, 1'h1, 32'h0000_0023);
        @(posedge clk);
        stop <= 1'h1;
        @(posedge clk);
        stop <= 1'h0;
        rd(ctrl_off, 32'h0000_0003);
        rd(stat_off, 32'h0000_0002);
        check(irq, 1'h0);
        wb(mask_off, 1'h1, 32'h0000_0003);
        repeat (2) @(posedge clk);
        check(irq, 1'h1);
        wb(stat_off, 1'h1, 32'h0000_0003);
        repeat (2) @(posedge clk);
        check(irq, 1'h0);
        test_done();
    end
endmodule : eight_bit_timer_counter_bench

// [tb/tmr8_event_src.sv]
// tmr8_event_src: external event pulse source for the timer's event input
// assumes the bench calls its tasks from one process, clocked by clk
`timescale 1ns/1ps
module tmr8_event_src (
    input wire logic clk,
    output logic event_input_pin
);
    // idle low between pulses
    initial event_input_pin = 1'h0;
    task automatic drive(input logic lvl);
        @(posedge clk);
        event_input_pin <= lvl;
        // random hold keeps the device from relying on a fixed phase
        repeat (8 + $urandom % 4) @(posedge clk);
    endtask : drive
    // one whole event pulse
    task automatic pulse();
        drive(1'h1);
        drive(1'h0);
    endtask : pulse
endmodule : tmr8_event_src

// [verilog/tmr8.sv]
// tmr8: 8-bit up-counting timer/counter with wishbone slave and interrupt logic
// assumes event_input_pin is synchronous to clk and stop_mode_req pulses on stop entry
`timescale 1ns/1ps
// Contract
// - stop mode entry clears the run bit
// - control bits 6 and 7 read don't care
// - timer match interrupts, clears, keeps counting
// - codes 000 to 011 give fixed ticks
// - event mode counts input rising edges
// - event match checked on falling edge
// - divider match toggles output, interrupts, clears
// - stopped counter drives divider output high
// - pulse output low on match, high overflow
// - pulse compare buffered until period ends
module tmr8 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic event_input_pin,
    input wire logic stop_mode_req,
    output logic divider_output_pin,
    output logic pulse_width_output_pin,
    output logic irq_o
);
    import tmr8_pkg::*;

    tmr_ctrl_t ctrl_r;          // timer_ctrl_reg
    logic [7:0] cmp_r;          // compare_value_reg as written
    logic [7:0] cmp_act_r;      // compare value in use (pulse mode shadow)
    logic [7:0] cnt_r;          // up-counter
    logic [11:0] pre_r;         // prescaler
    logic evt_d_r;              // previous event pin level
    logic evt_pend_r;           // count reached compare, waiting falling edge
    logic [1:0] stat_r;         // bit0 match/overflow interrupt, bit1 stop cleared run
    logic [1:0] mask_r;
    logic run_d_r;              // run bit one cycle ago for start detect

    // prescaler divisor per clock code; code 111 never ticks internally
    function automatic logic [11:0] tick_div(input logic [2:0] code);
        case (code)
            3'b000: tick_div = div_000;
            3'b001: tick_div = div_001;
            3'b010: tick_div = div_010;
            3'b011: tick_div = div_011;
            3'b100: tick_div = div_100;
            3'b101: tick_div = div_101;
            3'b110: tick_div = div_110;
            default: tick_div = 12'h0000;
        endcase
    endfunction : tick_div

    // bus decode
    logic bus_req;
    logic wr_ctrl;
    logic wr_cmp;
    logic wr_stat;
    logic wr_mask;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ctrl_off;
    assign wr_cmp = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == cmp_off;
    assign wr_stat = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == stat_off;
    assign wr_mask = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == mask_off;

    // timing strobes
    logic tick;
    logic evt_rise;
    logic evt_fall;
    logic start;
    logic match;
    assign tick = ctrl_r.run && ctrl_r.mode != mode_event
        && ctrl_r.clk_sel != 3'b111 && pre_r == 12'h001;
    assign evt_rise = event_input_pin && !evt_d_r;
    assign evt_fall = !event_input_pin && evt_d_r;
    assign start = ctrl_r.run && !run_d_r;
    assign match = cnt_r == cmp_act_r;

    // single cycle ack after one wait state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // read data mux; unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                ctrl_off: wb_dat_o <= {26'h000_0000, ctrl_r};
                cmp_off: wb_dat_o <= {24'h00_0000, cmp_r};
                stat_off: wb_dat_o <= {30'h0000_0000, stat_r};
                mask_off: wb_dat_o <= {30'h0000_0000, mask_r};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // control register; stop entry has priority over a write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= tmr_ctrl_t'(ctrl_rst[5:0]);
        end else if (stop_mode_req) begin
            ctrl_r.run <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_r <= tmr_ctrl_t'(wb_dat_i[5:0]);
        end
    end

    // start and event edge detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_d_r <= 1'b0;
            evt_d_r <= 1'b0;
        end else begin
            run_d_r <= ctrl_r.run;
            evt_d_r <= event_input_pin;
        end
    end

    // compare value as seen by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_r <= cmp_rst;
        end else if (wr_cmp) begin
            cmp_r <= wb_dat_i[7:0];
        end
    end

    // active compare: direct in most modes, buffered in pulse mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_act_r <= cmp_rst;
        end else if (ctrl_r.mode != mode_pulse) begin
            cmp_act_r <= cmp_r;
        // load on start or period end
        end else if (start || (tick && cnt_r == 8'hff)) begin
            cmp_act_r <= cmp_r;
        end
    end

    // prescaler reloads at the selected divisor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 12'h001;
        end else if (!ctrl_r.run || pre_r == 12'h001) begin
            pre_r <= tick_div(ctrl_r.clk_sel);
        end else begin
            pre_r <= pre_r - 12'h001;
        end
    end

    // up-counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
        end else if (!ctrl_r.run) begin
            cnt_r <= 8'h00;
        end else if (ctrl_r.mode == mode_event) begin
            if (evt_fall && evt_pend_r) begin
                cnt_r <= 8'h00;
            end else if (evt_rise) begin
                cnt_r <= cnt_r + 8'h01;
            end
        end else if (tick) begin
            if (ctrl_r.mode != mode_pulse && match) begin
                cnt_r <= 8'h00;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    // event mode pending match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_pend_r <= 1'b0;
        end else if (!ctrl_r.run || ctrl_r.mode != mode_event) begin
            evt_pend_r <= 1'b0;
        end else if (evt_fall) begin
            evt_pend_r <= 1'b0;
        end else if (match) begin
            evt_pend_r <= 1'b1;
        end
    end

    // interrupt event this cycle
    logic irq_evt;
    always_comb begin
        irq_evt = 1'b0;
        if (ctrl_r.run) begin
            case (ctrl_r.mode)
                mode_event: irq_evt = evt_fall && evt_pend_r;
                mode_pulse: irq_evt = tick && cnt_r == 8'hff;
                default: irq_evt = tick && match;
            endcase
        end
    end

    // divider output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divider_output_pin <= 1'b1;
        end else if (!ctrl_r.run || ctrl_r.mode != mode_divider) begin
            divider_output_pin <= 1'b1;
        end else if (tick && match) begin
            divider_output_pin <= !divider_output_pin;
        end
    end

    // pulse width output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_width_output_pin <= 1'b1;
        end else if (!ctrl_r.run || ctrl_r.mode != mode_pulse) begin
            pulse_width_output_pin <= 1'b1;
        end else if (tick && cnt_r == 8'hff) begin
            pulse_width_output_pin <= 1'b1;
        end else if (tick && match) begin
            pulse_width_output_pin <= 1'b0;
        end
    end

    // sticky status; a new event wins over a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= 2'b00;
        end else begin
            stat_r[0] <= irq_evt || (stat_r[0] && !(wr_stat && wb_dat_i[0]));
            stat_r[1] <= (stop_mode_req && ctrl_r.run)
                || (stat_r[1] && !(wr_stat && wb_dat_i[1]));
        end
    end

    // mask register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= 2'b00;
        end else if (wr_mask) begin
            mask_r <= wb_dat_i[1:0];
        end
    end

    // level interrupt from a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_r & mask_r);
        end
    end

    // tick spacing watch; the first tick after a start is skipped, its phase is free
    logic [3:0] gap_r;          // cycles since the last tick, saturating
    logic gap_ok_r;             // a tick has been seen since the run started
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= 4'h0;
            gap_ok_r <= 1'b0;
        end else if (!ctrl_r.run) begin
            gap_r <= 4'h0;
            gap_ok_r <= 1'b0;
        end else if (tick) begin
            gap_r <= 4'h0;
            gap_ok_r <= 1'b1;
        end else if (gap_r != 4'hf) begin
            gap_r <= gap_r + 4'h1;
        end
    end

    // assertions
    property p_stop_clears;
        @(posedge clk) disable iff (!rst_n) stop_mode_req |=> !ctrl_r.run;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("run not cleared on stop");

    property p_ctrl_hi_zero;
        @(posedge clk) disable iff (!rst_n)
            bus_req && !wb_we_i && wb_adr_i == ctrl_off |=> wb_dat_o[31:6] == 26'h000_0000;
    endproperty
    a_ctrl_hi_zero: assert property (p_ctrl_hi_zero) else $error("ctrl upper bits set");

    property p_timer_clear;
        @(posedge clk) disable iff (!rst_n)
            ctrl_r.run && ctrl_r.mode == mode_timer && tick && match && !stop_mode_req
            && !wr_ctrl |=> cnt_r == 8'h00 && stat_r[0];
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("timer match not cleared");

    property p_tick_period;
        @(posedge clk) disable iff (!rst_n)
            tick && gap_ok_r && ctrl_r.clk_sel == 3'b011
            |-> {8'h00, gap_r} == div_011 - 12'h001;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

    property p_event_count;
        @(posedge clk) disable iff (!rst_n)
            ctrl_r.run && ctrl_r.mode == mode_event && evt_rise && !wr_ctrl && !stop_mode_req
            |=> cnt_r == $past(cnt_r) + 8'h01;
    endproperty
    a_event_count: assert property (p_event_count) else $error("event not counted");

    property p_event_irq;
        @(posedge clk) disable iff (!rst_n)
            stat_r[0] && !$past(stat_r[0]) && ctrl_r.mode == mode_event |-> $past(evt_fall);
    endproperty
    a_event_irq: assert property (p_event_irq) else $error("event irq off falling edge");

    property p_div_toggle;
        @(posedge clk) disable iff (!rst_n)
            ctrl_r.run && ctrl_r.mode == mode_divider && tick && match && !wr_ctrl
            && !stop_mode_req |=> divider_output_pin != $past(divider_output_pin);
    endproperty
    a_div_toggle: assert property (p_div_toggle) else $error("divider not toggled");

    property p_div_idle_high;
        @(posedge clk) disable iff (!rst_n) !ctrl_r.run ##1 !ctrl_r.run |-> divider_output_pin;
    endproperty
    a_div_idle_high: assert property (p_div_idle_high) else $error("divider low stopped");

    property p_pulse_ovf;
        @(posedge clk) disable iff (!rst_n)
            ctrl_r.run && ctrl_r.mode == mode_pulse && tick && cnt_r == 8'hff && !wr_ctrl
            && !stop_mode_req |=> pulse_width_output_pin && stat_r[0];
    endproperty
    a_pulse_ovf: assert property (p_pulse_ovf) else $error("pulse overflow wrong");

    property p_pulse_buf;
        @(posedge clk) disable iff (!rst_n)
            ctrl_r.mode == mode_pulse && ctrl_r.run && !start && !(tick && cnt_r == 8'hff)
            |=> cmp_act_r == $past(cmp_act_r);
    endproperty
    a_pulse_buf: assert property (p_pulse_buf) else $error("pulse compare changed");

    property p_hold_zero;
        @(posedge clk) disable iff (!rst_n) !ctrl_r.run |=> cnt_r == 8'h00;
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("counter not held");
endmodule : tmr8

// [verilog/tmr8_pkg.sv]
// tmr8_pkg: register offsets, field positions, reset values and modes for the 8-bit timer
// assumes a 32-bit classic wishbone register bus and a single 20 mhz system clock
package tmr8_pkg;
    // register byte offsets
    localparam logic [3:0] ctrl_off = 4'h0;     // timer_ctrl_reg
    localparam logic [3:0] cmp_off = 4'h4;      // compare_value_reg
    localparam logic [3:0] stat_off = 4'h8;     // interrupt status, write one to clear
    localparam logic [3:0] mask_off = 4'hc;     // interrupt mask
    // control field positions
    localparam int ck_lsb = 0;                  // source_clock_select, 3 bits
    localparam int mode_lsb = 3;                // operating_mode_field, 2 bits
    localparam int run_pos = 5;                 // run_bit
    // reset values
    localparam logic [7:0] ctrl_rst = 8'h00;
    localparam logic [7:0] cmp_rst = 8'hff;
    // tick periods in system clocks for codes 000..011 (prescaled internal clock)
    localparam int clk_mhz = 20;
    localparam logic [11:0] div_000 = 12'h0a00; // 128 us at 20 mhz
    localparam logic [11:0] div_001 = 12'h00a0; // 8 us
    localparam logic [11:0] div_010 = 12'h0028; // 2 us
    localparam logic [11:0] div_011 = 12'h000a; // 0.5 us
    localparam logic [11:0] div_100 = 12'h0004;
    localparam logic [11:0] div_101 = 12'h0002;
    localparam logic [11:0] div_110 = 12'h0001;

    // operating modes
    typedef enum logic [1:0] {
        mode_timer = 2'b00,
        mode_event = 2'b01,
        mode_divider = 2'b10,
        mode_pulse = 2'b11
    } tmr_mode_t;

    // control register image
    typedef struct packed {
        logic run;
        tmr_mode_t mode;
        logic [2:0] clk_sel;
    } tmr_ctrl_t;
endpackage : tmr8_pkg
